// ==== rtl/pqs_port_qos.v ====
`timescale 1ns/1ps
`include "pqs_regs.vh"

module pqs_port_qos #(
  parameter NPORTS      = 8,
  parameter OCC_W       = 10,
  parameter BURST_BYTES = 16384
) (
  // clock and reset
  input  wire              clk,
  input  wire              reset,
  // axi4-lite slave
  input  wire [7:0]        s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [7:0]        s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // ingress frame descriptors from the fabric
  input  wire              in_valid,
  output reg               in_ready,
  input  wire [2:0]        in_tag,
  input  wire [1:0]        in_kind,
  input  wire [15:0]       in_bytes,
  input  wire [NPORTS-1:0] in_dest_mask,
  input  wire [NPORTS-1:0] in_vlan_mask,
  // enqueue and drop decisions
  output reg               enq_valid,
  output reg  [1:0]        enq_queue,
  output reg               enq_flood,
  output reg  [NPORTS-1:0] enq_port_mask,
  output reg               drop_valid,
  output reg               drop_storm,
  // egress grant towards the mac
  output reg               tx_valid,
  output reg  [1:0]        tx_queue,
  input  wire              tx_ready,
  input  wire              tx_done,
  input  wire [15:0]       tx_bytes
);

  localparam [1:0] lowest_egress_queue  = 2'h0;
  localparam [1:0] second_egress_queue  = 2'h1;
  localparam [1:0] third_egress_queue   = 2'h2;
  localparam [1:0] highest_egress_queue = 2'h3;

  localparam [1:0] ST_PICK  = 2'b01;
  localparam [1:0] ST_OFFER = 2'b10;

  localparam [OCC_W-1:0] OCC_MAX = {OCC_W{1'b1}};

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  function [1:0] tag_to_queue;
    input [2:0] tag;
    begin
      case (tag)
        3'h1, 3'h2: tag_to_queue = lowest_egress_queue;
        3'h0, 3'h3: tag_to_queue = second_egress_queue;
        3'h4, 3'h5: tag_to_queue = third_egress_queue;
        default:    tag_to_queue = highest_egress_queue;
      endcase
    end
  endfunction

  // highest set bit wins: {found, index}
  function [2:0] pick_high;
    input [3:0] elig;
    begin
      if (elig[3])
        pick_high = {1'b1, highest_egress_queue};
      else if (elig[2])
        pick_high = {1'b1, third_egress_queue};
      else if (elig[1])
        pick_high = {1'b1, second_egress_queue};
      else if (elig[0])
        pick_high = {1'b1, lowest_egress_queue};
      else
        pick_high = 3'h0;
    end
  endfunction

  // next eligible after the last served: {found, index}
  function [2:0] rr_pick;
    input [3:0] elig;
    input [1:0] last;
    integer     i;
    reg   [1:0] c;
    begin
      rr_pick = 3'h0;
      c = 2'h0;
      for (i = 4; i >= 1; i = i - 1) begin
        c = last + i[1:0];
        if (elig[c])
          rr_pick = {1'b1, c};
      end
    end
  endfunction

  function [31:0] apply_strb;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer      b;
    begin
      apply_strb = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b])
          apply_strb[8*b +: 8] = data[8*b +: 8];
      end
    end
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  reg [3:0]       strict_mask;
  reg [31:0]      weights;
  reg [31:0]      rx_cfg;
  reg [31:0]      tx_cfg;
  reg [31:0]      storm_cfg;
  reg [31:0]      rate_drops;
  reg [31:0]      storm_drops;
  reg [OCC_W-1:0] occ [0:3];
  reg [7:0]       credit [0:3];
  reg [1:0]       last_wrr;
  reg [1:0]       state;
  reg             aw_got;
  reg             w_got;
  reg [7:0]       aw_addr;
  reg [31:0]      w_data;
  reg [3:0]       w_strb;

  wire rx_allow;
  wire tx_allow;
  wire storm_allow;

  // ------------------------------------------------------------
  // ingress decision
  // ------------------------------------------------------------
  wire       take      = in_valid & in_ready;
  wire [1:0] in_q      = tag_to_queue(in_tag);
  wire       flooded   = (in_kind != `PQS_KIND_UNICAST);
  wire       storm_en  =
    ((in_kind == `PQS_KIND_BCAST)   & storm_cfg[`PQS_STORM_BC_BIT]) |
    ((in_kind == `PQS_KIND_MCAST)   & storm_cfg[`PQS_STORM_MC_BIT]) |
    ((in_kind == `PQS_KIND_UNKNOWN) & storm_cfg[`PQS_STORM_UU_BIT]);
  wire       storm_hit = storm_en & ~storm_allow;
  wire       rate_hit  = ~rx_allow | (occ[in_q] == OCC_MAX);
  wire       drop      = storm_hit | rate_hit;
  wire       accept    = take & ~drop;

  pqs_rate_limiter #(
    .MIN_KBPS    (`PQS_RX_MIN_KBPS),
    .MAX_KBPS    (`PQS_RX_MAX_KBPS),
    .BURST_BYTES (BURST_BYTES)
  ) u_rx_limit (
    .clk          (clk),
    .reset        (reset),
    .unlimited    (rx_cfg[`PQS_UNLIM_BIT]),
    .rate_kbps    (rx_cfg[`PQS_RATE_MSB:0]),
    .charge       (accept),
    .charge_bytes (in_bytes),
    .allow        (rx_allow)
  );

  pqs_rate_limiter #(
    .MIN_KBPS    (`PQS_RX_MIN_KBPS),
    .MAX_KBPS    (`PQS_RX_MAX_KBPS),
    .BURST_BYTES (BURST_BYTES)
  ) u_storm_limit (
    .clk          (clk),
    .reset        (reset),
    .unlimited    (1'b0),
    .rate_kbps    (storm_cfg[`PQS_RATE_MSB:0]),
    .charge       (accept & storm_en),
    .charge_bytes (in_bytes),
    .allow        (storm_allow)
  );

  pqs_rate_limiter #(
    .MIN_KBPS    (`PQS_TX_MIN_KBPS),
    .MAX_KBPS    (`PQS_TX_MAX_KBPS),
    .BURST_BYTES (BURST_BYTES)
  ) u_tx_limit (
    .clk          (clk),
    .reset        (reset),
    .unlimited    (tx_cfg[`PQS_UNLIM_BIT]),
    .rate_kbps    (tx_cfg[`PQS_RATE_MSB:0]),
    .charge       (tx_done),
    .charge_bytes (tx_bytes),
    .allow        (tx_allow)
  );

  // ------------------------------------------------------------
  // egress selection
  // ------------------------------------------------------------
  reg [3:0] nonempty;
  reg [3:0] weight_nz;
  reg [3:0] credit_nz;
  integer   k;
  integer   j;

  always @* begin
    for (k = 0; k < 4; k = k + 1) begin
      nonempty[k]  = (occ[k] != {OCC_W{1'b0}});
      weight_nz[k] = (weights[8*k +: 8] != 8'h00);
      credit_nz[k] = (credit[k] != 8'h00);
    end
  end

  wire [3:0] strict_elig = nonempty & strict_mask;
  wire [3:0] wrr_active  = nonempty & ~strict_mask & weight_nz;
  wire [3:0] wrr_elig    = wrr_active & credit_nz;
  wire [2:0] strict_sel  = pick_high(strict_elig);
  wire [2:0] wrr_sel     = rr_pick(wrr_elig, last_wrr);
  wire       can_pick    = (state == ST_PICK) & tx_allow;
  wire       pick_strict = can_pick & strict_sel[2];
  wire       pick_wrr    = can_pick & ~strict_sel[2] & wrr_sel[2];
  wire       new_round   = can_pick & ~strict_sel[2] & ~wrr_sel[2] &
                           (wrr_active != 4'h0);
  wire [1:0] deq_q       = pick_strict ? strict_sel[1:0] : wrr_sel[1:0];
  wire       deq         = pick_strict | pick_wrr;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state    <= ST_PICK;
      tx_valid <= 1'b0;
      tx_queue <= 2'h0;
      last_wrr <= 2'h3;
      for (j = 0; j < 4; j = j + 1) begin
        occ[j]    <= {OCC_W{1'b0}};
        credit[j] <= 8'h00;
      end
    end else begin
      for (j = 0; j < 4; j = j + 1) begin
        if (accept && (in_q == j[1:0]) && !(deq && (deq_q == j[1:0])))
          occ[j] <= occ[j] + {{(OCC_W-1){1'b0}}, 1'b1};
        else if (!(accept && (in_q == j[1:0])) && deq && (deq_q == j[1:0]))
          occ[j] <= occ[j] - {{(OCC_W-1){1'b0}}, 1'b1};
        if (new_round)
          credit[j] <= weights[8*j +: 8];
      end
      if (pick_wrr) begin
        credit[wrr_sel[1:0]] <= credit[wrr_sel[1:0]] - 8'h01;
        last_wrr <= wrr_sel[1:0];
      end
      case (state)
        ST_PICK: begin
          if (deq) begin
            tx_valid <= 1'b1;
            tx_queue <= deq_q;
            state    <= ST_OFFER;
          end
        end
        ST_OFFER: begin
          if (tx_ready) begin
            tx_valid <= 1'b0;
            state    <= ST_PICK;
          end
        end
        default: begin
          tx_valid <= 1'b0;
          state    <= ST_PICK;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // ingress handshake and decisions
  // ------------------------------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      in_ready      <= 1'b0;
      enq_valid     <= 1'b0;
      enq_queue     <= 2'h0;
      enq_flood     <= 1'b0;
      enq_port_mask <= {NPORTS{1'b0}};
      drop_valid    <= 1'b0;
      drop_storm    <= 1'b0;
    end else begin
      enq_valid  <= accept;
      drop_valid <= take & drop;
      in_ready   <= ~take;
      if (take) begin
        enq_queue     <= in_q;
        enq_flood     <= flooded;
        drop_storm    <= storm_hit;
        enq_port_mask <= flooded ? in_vlan_mask : in_dest_mask;
      end
    end
  end

  // ------------------------------------------------------------
  // register read mux
  // ------------------------------------------------------------
  reg [31:0] rd_word;
  reg        rd_ok;

  always @*
    begin
      rd_ok = 1'b1;
      case (s_axi_araddr)
        `PQS_OFF_MODE:        rd_word = {28'h000_0000, strict_mask};
        `PQS_OFF_WEIGHTS:     rd_word = weights;
        `PQS_OFF_RX_CFG:      rd_word = rx_cfg;
        `PQS_OFF_TX_CFG:      rd_word = tx_cfg;
        `PQS_OFF_STORM_CFG:   rd_word = storm_cfg;
        `PQS_OFF_STATUS:      rd_word = {20'h0_0000, storm_allow, tx_allow,
                                         rx_allow, tx_valid, 2'h0,
                                         tx_queue, nonempty};
        `PQS_OFF_RATE_DROPS:  rd_word = rate_drops;
        `PQS_OFF_STORM_DROPS: rd_word = storm_drops;
        default: begin
          rd_word = 32'h0000_0000;
          rd_ok   = 1'b0;
        end
      endcase
    end

  // ------------------------------------------------------------
  // axi4-lite slave and configuration
  // ------------------------------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PQS_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `PQS_RESP_OKAY;
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      strict_mask   <= `PQS_RST_MODE;
      weights       <= `PQS_RST_WEIGHTS;
      rx_cfg        <= `PQS_RST_RX_CFG;
      tx_cfg        <= `PQS_RST_TX_CFG;
      storm_cfg     <= `PQS_RST_STORM_CFG;
      rate_drops    <= 32'h0000_0000;
      storm_drops   <= 32'h0000_0000;
    end else begin
      if (take && storm_hit)
        storm_drops <= storm_drops + 32'h0000_0001;
      else if (take && rate_hit)
        rate_drops <= rate_drops + 32'h0000_0001;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got        <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got        <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (aw_got && w_got && !s_axi_bvalid) begin
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `PQS_RESP_OKAY;
        case (aw_addr)
          `PQS_OFF_MODE: begin
            if (w_strb[0])
              strict_mask <= w_data[3:0];
          end
          `PQS_OFF_WEIGHTS:
            weights <= apply_strb(weights, w_data, w_strb);
          `PQS_OFF_RX_CFG:
            rx_cfg <= apply_strb(rx_cfg, w_data, w_strb) & 32'h800F_FFFF;
          `PQS_OFF_TX_CFG:
            tx_cfg <= apply_strb(tx_cfg, w_data, w_strb) & 32'h800F_FFFF;
          `PQS_OFF_STORM_CFG:
            storm_cfg <= apply_strb(storm_cfg, w_data, w_strb) &
                         32'h070F_FFFF;
          `PQS_OFF_STATUS, `PQS_OFF_RATE_DROPS, `PQS_OFF_STORM_DROPS: begin
          end
          default:
            s_axi_bresp <= `PQS_RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_ok ? `PQS_RESP_OKAY : `PQS_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // pqs_port_qos

// ==== rtl/pqs_regs.vh ====
`ifndef PQS_REGS_VH
`define PQS_REGS_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define PQS_OFF_MODE         8'h00
`define PQS_OFF_WEIGHTS      8'h04
`define PQS_OFF_RX_CFG       8'h08
`define PQS_OFF_TX_CFG       8'h0C
`define PQS_OFF_STORM_CFG    8'h10
`define PQS_OFF_STATUS       8'h14
`define PQS_OFF_RATE_DROPS   8'h18
`define PQS_OFF_STORM_DROPS  8'h1C

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define PQS_RST_MODE         4'hF
`define PQS_RST_WEIGHTS      32'h0804_0201
`define PQS_RST_RX_CFG       32'h8000_0DAC
`define PQS_RST_TX_CFG       32'h8000_0040
`define PQS_RST_STORM_CFG    32'h0000_0DAC

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define PQS_UNLIM_BIT        31
`define PQS_RATE_MSB         19
`define PQS_STORM_BC_BIT     24
`define PQS_STORM_MC_BIT     25
`define PQS_STORM_UU_BIT     26

// ------------------------------------------------------------
// frame kinds and bus answers
// ------------------------------------------------------------
`define PQS_KIND_UNICAST     2'h0
`define PQS_KIND_BCAST       2'h1
`define PQS_KIND_MCAST       2'h2
`define PQS_KIND_UNKNOWN     2'h3
`define PQS_RESP_OKAY        2'h0
`define PQS_RESP_SLVERR      2'h2

// ------------------------------------------------------------
// rate limits and timing
// ------------------------------------------------------------
`define PQS_RX_MIN_KBPS      3500
`define PQS_RX_MAX_KBPS      1000000
`define PQS_TX_MIN_KBPS      64
`define PQS_TX_MAX_KBPS      1000000
`define PQS_CLK_PERIOD_NS    4
`define PQS_TICK_NS          1000
`define PQS_TICK_CYCLES      (`PQS_TICK_NS / `PQS_CLK_PERIOD_NS)
`define PQS_MBIT_PER_BYTE    40'h00_0000_1F40

`endif

// ==== rtl/pqs_rate_limiter.v ====
`timescale 1ns/1ps
`include "pqs_regs.vh"

module pqs_rate_limiter #(
  parameter MIN_KBPS    = 3500,
  parameter MAX_KBPS    = 1000000,
  parameter BURST_BYTES = 16384
) (
  // clock and reset
  input  wire        clk,
  input  wire        reset,
  // configuration
  input  wire        unlimited,
  input  wire [19:0] rate_kbps,
  // usage
  input  wire        charge,
  input  wire [15:0] charge_bytes,
  output reg         allow
);

  localparam [19:0]        MIN_R     = MIN_KBPS;
  localparam [19:0]        MAX_R     = MAX_KBPS;
  localparam [15:0]        TICK_LAST = `PQS_TICK_CYCLES - 1;
  localparam signed [39:0] CAP       = BURST_BYTES * `PQS_MBIT_PER_BYTE;

  reg signed [39:0] credit;
  reg        [15:0] tick_cnt;
  reg        [19:0] eff;
  reg signed [39:0] cost;
  reg signed [39:0] next_credit;

  // credit in millibits: kbps equals millibits per microsecond
  always @* begin
    eff = rate_kbps;
    if (eff < MIN_R)
      eff = MIN_R;
    if (eff > MAX_R)
      eff = MAX_R;
    cost = $signed({24'h00_0000, charge_bytes}) * $signed(`PQS_MBIT_PER_BYTE);
    next_credit = credit;
    if (tick_cnt == TICK_LAST)
      next_credit = next_credit + $signed({20'h0_0000, eff});
    if (charge)
      next_credit = next_credit - cost;
    if (next_credit > CAP)
      next_credit = CAP;
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      credit   <= 40'sh00_0000_0000;
      tick_cnt <= 16'h0000;
      allow    <= 1'b1;
    end else begin
      tick_cnt <= (tick_cnt == TICK_LAST) ? 16'h0000 : tick_cnt + 16'h0001;
      if (unlimited) begin
        credit <= CAP;
        allow  <= 1'b1;
      end else begin
        credit <= next_credit;
        allow  <= (next_credit >= 0);
      end
    end
  end

endmodule // pqs_rate_limiter

// ==== verif/pqs_assertions.sv ====
`timescale 1ns/1ps

module pqs_checker #(
  parameter NPORTS = 8
) (
  // clock and reset
  input wire              clk,
  input wire              reset,
  // register bus
  input wire              s_axi_awvalid,
  input wire              s_axi_awready,
  input wire              s_axi_wvalid,
  input wire              s_axi_wready,
  input wire [1:0]        s_axi_bresp,
  input wire              s_axi_bvalid,
  input wire              s_axi_bready,
  // ingress
  input wire              in_valid,
  input wire              in_ready,
  input wire [2:0]        in_tag,
  input wire [1:0]        in_kind,
  input wire [NPORTS-1:0] in_vlan_mask,
  input wire              enq_valid,
  input wire [1:0]        enq_queue,
  input wire              enq_flood,
  input wire [NPORTS-1:0] enq_port_mask,
  input wire              drop_valid,
  input wire              drop_storm,
  // egress
  input wire              tx_valid,
  input wire [1:0]        tx_queue,
  input wire              tx_ready
);
  // ----------------------------------------------------------
  // port relations
  // ----------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  wire take = in_valid && in_ready;

  function [1:0] qmap(input [2:0] t);
    qmap = (t == 3'h0 || t == 3'h3) ? 2'h1 :
           (t == 3'h1 || t == 3'h2) ? 2'h0 : {1'h1, t[1]};
  endfunction

  property p_answer;
    take |=> enq_valid != drop_valid;
  endproperty
  a_answer: assert property (p_answer) else $error("no single answer");

  property p_gap;
    take |=> !in_ready;
  endproperty
  a_gap: assert property (p_gap) else $error("ready after take");

  property p_map;
    take |=> !enq_valid || enq_queue == qmap($past(in_tag));
  endproperty
  a_map: assert property (p_map) else $error("wrong queue");

  property p_flood;
    take && in_kind != 2'h0 |=> !enq_valid ||
      (enq_flood && enq_port_mask == $past(in_vlan_mask));
  endproperty
  a_flood: assert property (p_flood) else $error("bad flood");

  property p_storm;
    take && in_kind == 2'h0 |=> !(drop_valid && drop_storm);
  endproperty
  a_storm: assert property (p_storm) else $error("storm drop");

  property p_grant;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_queue);
  endproperty
  a_grant: assert property (p_grant) else $error("grant moved");

  property p_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> ##1 s_axi_bvalid;
  endproperty
  a_wr: assert property (p_wr) else $error("no write answer");

  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("answer dropped");
endmodule // pqs_checker

bind pqs_port_qos pqs_checker #(.NPORTS(NPORTS)) i_chk (
  .clk, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .in_valid,
  .in_ready, .in_tag, .in_kind, .in_vlan_mask, .enq_valid, .enq_queue,
  .enq_flood, .enq_port_mask, .drop_valid, .drop_storm, .tx_valid,
  .tx_queue, .tx_ready
);

// ==== verif/pqs_mac_model.sv ====
`timescale 1ns/1ps

module pqs_mac_model (
  // clock and reset
  input  wire        clk,
  input  wire        reset,
  // grant side
  input  wire        tx_valid,
  input  wire [1:0]  tx_queue,
  input  wire        hold,
  output reg         tx_ready,
  output reg         tx_done,
  output reg  [15:0] tx_bytes
);
  // ----------------------------------------------------------
  // mac taking grants, logging served queues
  // ----------------------------------------------------------
  reg [1:0] log_q [0:63];
  integer   n_taken;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_ready <= 1'h0;
      tx_done  <= 1'h0;
      tx_bytes <= 16'h0000;
      n_taken  <= 0;
    end else begin
      tx_ready <= !hold;
      tx_done  <= tx_valid && tx_ready;
      // length only valid with done
      tx_bytes <= (tx_valid && tx_ready) ? 16'h0040 : ~tx_bytes;
      if (tx_valid && tx_ready) begin
        log_q[n_taken] <= tx_queue;
        n_taken <= n_taken + 1;
      end
    end
  end
endmodule // pqs_mac_model

// ==== verif/pqs_port_qos_tb.sv ====
`timescale 1ns/1ps
`include "pqs_regs.vh"

module pqs_port_qos_tb;
  // ----------------------------------------------------------
  // signals
  // ----------------------------------------------------------
  reg         clk = 1'h0;
  reg         reset = 1'h1;
  reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg  [31:0] s_axi_wdata = 32'h0000_0000;
  reg  [3:0]  s_axi_wstrb = 4'h0;
  reg         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  reg         s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, in_valid = 1'h0;
  reg  [2:0]  in_tag = 3'h0;
  reg  [1:0]  in_kind = 2'h0;
  reg  [15:0] in_bytes = 16'h0100;
  reg  [7:0]  in_dest_mask = 8'h01, in_vlan_mask = 8'h0f;
  reg         slow = 1'h0;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire        s_axi_rvalid, in_ready, enq_valid, enq_flood, drop_valid;
  wire        drop_storm, tx_valid, tx_ready, tx_done;
  wire [1:0]  s_axi_bresp, s_axi_rresp, enq_queue, tx_queue;
  wire [31:0] s_axi_rdata;
  wire [7:0]  enq_port_mask;
  wire [15:0] tx_bytes;
  integer     failures = 0, checks_done = 0, cycles = 0, i;
  reg  [3:0]  cnt [0:3];
  localparam [15:0] TAG_MAP  = 16'hfa41;
  localparam [11:0] WRR_TAGS = 12'hd01;

  always #2 clk = ~clk;

  pqs_port_qos #(.BURST_BYTES(64)) i_dut (
    .clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .in_valid, .in_ready, .in_tag, .in_kind, .in_bytes, .in_dest_mask,
    .in_vlan_mask, .enq_valid, .enq_queue, .enq_flood, .enq_port_mask,
    .drop_valid, .drop_storm, .tx_valid, .tx_queue, .tx_ready, .tx_done,
    .tx_bytes
  );

  pqs_mac_model i_mac (
    .clk, .reset, .tx_valid, .tx_queue, .hold(slow & cycles[1]),
    .tx_ready, .tx_done, .tx_bytes
  );

  task chk(input [8*6-1:0] name, input [31:0] exp, input [31:0] got);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("ERROR %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask

  task wr(input [7:0] a, input [31:0] v, input [1:0] rsp);
    reg aw_done;
    reg w_done;
    begin
      s_axi_awaddr  <= a;
      s_axi_wdata   <= v;
      s_axi_wstrb   <= 4'hf;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid  <= 1'h1;
      aw_done = 1'h0;
      w_done  = 1'h0;
      while (!(aw_done && w_done)) begin
        @(posedge clk);
        if (s_axi_awready && !aw_done) begin
          aw_done = 1'h1;
          s_axi_awvalid <= 1'h0;
        end
        if (s_axi_wready && !w_done) begin
          w_done = 1'h1;
          s_axi_wvalid <= 1'h0;
        end
      end
      @(posedge clk);
      while (!s_axi_bvalid) @(posedge clk);
      s_axi_bready <= 1'h1;
      @(posedge clk);
      chk("bresp", rsp, s_axi_bresp);
      s_axi_bready <= 1'h0;
    end
  endtask

  task rd(input [7:0] a, input [31:0] v, input [1:0] rsp);
    begin
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'h1;
      @(posedge clk);
      while (!s_axi_arready) @(posedge clk);
      s_axi_arvalid <= 1'h0;
      s_axi_rready  <= 1'h1;
      @(posedge clk);
      while (!s_axi_rvalid) @(posedge clk);
      chk("rdata", v, s_axi_rdata);
      chk("rresp", rsp, s_axi_rresp);
      s_axi_rready <= 1'h0;
    end
  endtask

  task send(input [2:0] tag, input [1:0] kind, input drop);
    begin
      in_tag   <= tag;
      in_kind  <= kind;
      in_valid <= 1'h1;
      @(posedge clk);
      while (!in_ready) @(posedge clk);
      in_valid <= 1'h0;
      @(posedge clk);
      chk("drop", drop, drop_valid);
      if (drop) begin
        chk("storm", kind != 2'h0, drop_storm);
      end else begin
        chk("queue", TAG_MAP[2*tag +: 2], enq_queue);
        chk("mask", kind ? 32'h0f : 32'h01, enq_port_mask);
        chk("flood", kind != 2'h0, enq_flood);
      end
    end
  endtask

  task print_verdict;
    begin
      if (failures == 0 && checks_done > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask

  // ----------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      failures = failures + 1;
      print_verdict;
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    rd(`PQS_OFF_MODE, `PQS_RST_MODE, `PQS_RESP_OKAY);
    rd(`PQS_OFF_WEIGHTS, `PQS_RST_WEIGHTS, `PQS_RESP_OKAY);
    rd(`PQS_OFF_RX_CFG, `PQS_RST_RX_CFG, `PQS_RESP_OKAY);
    rd(`PQS_OFF_TX_CFG, `PQS_RST_TX_CFG, `PQS_RESP_OKAY);
    wr(`PQS_OFF_WEIGHTS, 32'h0000_0000, `PQS_RESP_OKAY);
    wr(`PQS_OFF_MODE, 32'h0000_0000, `PQS_RESP_OKAY);
    for (i = 0; i < 8; i = i + 1)
      send(i, 2'h0, 1'h0);
    repeat (50) @(posedge clk);
    chk("taken", 0, i_mac.n_taken);
    wr(`PQS_OFF_MODE, 32'h0000_000f, `PQS_RESP_OKAY);
    while (i_mac.n_taken < 8) @(posedge clk);
    for (i = 0; i < 8; i = i + 1)
      chk("order", 3 - i / 2, i_mac.log_q[i]);
    wr(`PQS_OFF_MODE, 32'h0000_0000, `PQS_RESP_OKAY);
    slow <= 1'h1;
    for (i = 0; i < 16; i = i + 1)
      send(WRR_TAGS[3*(i%4) +: 3], 2'h0, 1'h0);
    wr(`PQS_OFF_WEIGHTS, 32'h0001_0203, `PQS_RESP_OKAY);
    while (i_mac.n_taken < 14) @(posedge clk);
    for (i = 0; i < 4; i = i + 1)
      cnt[i] = 4'h0;
    for (i = 8; i < 14; i = i + 1)
      cnt[i_mac.log_q[i]] = cnt[i_mac.log_q[i]] + 4'h1;
    for (i = 0; i < 4; i = i + 1)
      chk("share", 3 - i, cnt[i]);
    wr(`PQS_OFF_STORM_CFG, 32'h0100_0dac, `PQS_RESP_OKAY);
    send(3'h0, `PQS_KIND_BCAST, 1'h0);
    send(3'h0, `PQS_KIND_BCAST, 1'h1);
    send(3'h0, `PQS_KIND_UNICAST, 1'h0);
    rd(`PQS_OFF_STORM_DROPS, 32'h0000_0001, `PQS_RESP_OKAY);
    wr(`PQS_OFF_RX_CFG, 32'h0000_0dac, `PQS_RESP_OKAY);
    send(3'h0, `PQS_KIND_UNICAST, 1'h0);
    send(3'h0, `PQS_KIND_UNICAST, 1'h1);
    rd(`PQS_OFF_RATE_DROPS, 32'h0000_0001, `PQS_RESP_OKAY);
    wr(8'h24, 32'h0000_0000, `PQS_RESP_SLVERR);
    rd(8'h20, 32'h0000_0000, `PQS_RESP_SLVERR);
    print_verdict;
  end
endmodule // pqs_port_qos_tb
